// >>> core/can_message_buffer_store.sv
// Transmit buffers, priority pick, abort, receive FIFO and time stamps
//
// Contract
// R1 - Every buffer with empty flag clear joins the pick just before SOF.
// R2 - Lowest priority value wins; on ties the lower buffer index wins.
// R3 - Each of three buffers holds an 8-bit priority, smaller is higher.
// R4 - Priority access only while buffer empty and currently selected.
// R5 - With stamping on, timer is stored into active buffer on acknowledge.
// R6 - Stamp timer counts bit time, wraps silently, zero in init mode.
// R7 - Stamp bytes are read-only; transmit stamps readable when empty, selected.
// R8 - Three transmit buffers of 13 message bytes, priority, two stamp bytes.
// R9 - Software selects an empty buffer; it appears in one transmit window.
// R10 - Clearing the empty flag requests sending; success sets it again.
// R11 - A transmit event fires whenever a buffer empty flag becomes set; init mode sets the flags without an event.
// R12 - The pick reruns at every arbitration, also after an error.
// R13 - Abort request on a buffer not sending sets ack, empty, event.
// R14 - On release the abort ack reads 1 if aborted, 0 if sent.
// R15 - Five-entry FIFO of 15-byte buffers; background buffer is hidden.
// R16 - Receive-full is set while the foreground holds an accepted message.
// R17 - A valid accepted message is shifted in, sets full, fires an event.
// R18 - Software reads the foreground then clears full to release it.
// R19 - Rejected or faulty messages never enter the FIFO.
// R20 - Own frames are captured but not queued unless in loopback.
// R21 - After lost arbitration the winning frame is received in full.
// R22 - A full FIFO discards new accepted messages and flags overrun.
// R23 - Length code gives 0..8 data bytes; remote frames send none.
// R24 - Reset or init leaves all buffers empty and the FIFO empty.
//
// The register offsets and strobed register access were decided locally.
`timescale 1ns/1ps
`default_nettype none
`include "can_msg_params.svh"
module can_message_buffer_store #(
  parameter int RX_DEPTH = `RX_DEPTH_DEF, // Receive FIFO stages
  parameter int BIT_DIV = `BIT_DIV_DEF // Clock cycles per CAN bit
) (
  input wire logic mclk_i, // Controller clock
  input wire logic rst_n_i, // Synchronous reset, low
  input wire logic [7:0] reg_addr_i, // Register address
  input wire logic [7:0] reg_wdata_i, // Register write data
  input wire logic reg_wr_i, // Write strobe
  input wire logic reg_rd_i, // Read strobe
  output logic [7:0] reg_rdata_o, // Read data, cycle after strobe
  input wire logic sof_req_i, // Engine about to send SOF
  input wire logic tx_start_i, // Picked buffer now on the bus
  input wire logic tx_done_i, // Own frame sent successfully
  input wire logic tx_error_i, // Transmission error, retry later
  input wire logic arb_lost_i, // Arbitration lost
  input wire logic bus_ack_i, // Message acknowledged on the bus
  output can_msg_pkg::tx_pick_t tx_pick_o, // Picked buffer
  output logic [8*`MSG_BYTES-1:0] tx_msg_o, // Picked message bytes
  input wire can_msg_pkg::rx_wr_t rx_wr_i, // Byte into background buffer
  input wire logic rx_ok_i, // Frame received without error
  input wire logic accept_hit_i, // Identifier passed the filter
  output logic [2:0] tx_buffer_empty_o, // Empty flags
  output logic [2:0] tx_event_o, // Empty flag became set
  output logic rx_full_flag_o, // Foreground holds a message
  output logic rx_event_o, // Message shifted into FIFO
  output logic overrun_event_o // Message lost to full FIFO
);
  import can_msg_pkg::*;

  localparam int PW = $clog2(RX_DEPTH + 1);
  localparam int DW = $clog2(BIT_DIV + 1);

  byte_t tx_mem [3][`MSG_BYTES];
  byte_t tx_local_priority_field_r [3];
  logic [15:0] tx_stamp_r [3];
  byte_t bg_mem [`RX_BYTES];
  byte_t rx_mem [RX_DEPTH][`RX_BYTES];
  logic [2:0] ctrl_r;
  logic [2:0] txe_r;
  logic [2:0] txe_nxt;
  logic [2:0] sel_r;
  logic [2:0] abt_req_r;
  logic [2:0] abt_req_nxt;
  logic [2:0] abt_ack_r;
  logic [2:0] abt_ack_nxt;
  logic in_tx_r;
  logic in_tx_nxt;
  logic [1:0] act_r;
  tx_pick_t tx_pick_r;
  logic [8*`MSG_BYTES-1:0] tx_msg_r;
  logic [15:0] timer_r;
  logic [DW-1:0] div_r;
  logic [PW-1:0] rd_ptr_r;
  logic [PW-1:0] wr_ptr_r;
  logic [PW-1:0] rx_cnt_r;
  logic ovr_r;
  logic [2:0] tx_ev_r;
  logic rx_ev_r;
  logic ovr_ev_r;
  logic [7:0] rdata_r;
  logic [7:0] rd_val;
  logic [1:0] best;
  logic found;

  default clocking cb @(posedge mclk_i);
  endclocking
  default disable iff (!rst_n_i);

  // Lowest set bit position of a three-bit vector
  function automatic logic [1:0] first_one(input logic [2:0] v);
    if (v[0])
    begin
      return 2'd0;
    end
    else if (v[1])
    begin
      return 2'd1;
    end
    return 2'd2;
  endfunction : first_one

  // Data bytes actually sent: none for remote frames, at most eight
  function automatic logic [3:0] data_count(input byte_t idr1, input byte_t idr3,
                                            input byte_t dlr);
    logic rtr;
    rtr = idr1[`IDE_BIT] ? idr3[`RTR_EXT_BIT] : idr1[`RTR_STD_BIT];
    if (rtr)
    begin
      return 4'h0;
    end
    return (dlr[3:0] > `MAX_DATA) ? `MAX_DATA : dlr[3:0];
  endfunction : data_count

  // Circular FIFO pointer step
  function automatic logic [PW-1:0] ptr_inc(input logic [PW-1:0] p);
    return (p == PW'(RX_DEPTH - 1)) ? '0 : p + PW'(1);
  endfunction : ptr_inc

  // Decode helpers
  wire logic init_w = ctrl_r[`CTRL_INIT_BIT];
  wire logic time_w = ctrl_r[`CTRL_TIME_BIT];
  wire logic loop_w = ctrl_r[`CTRL_LOOP_BIT];
  wire logic [3:0] win_idx = reg_addr_i[3:0];
  wire logic tx_page = reg_addr_i[7:4] == `TX_PAGE;
  wire logic rx_page = reg_addr_i[7:4] == `RX_PAGE;
  wire logic [1:0] sidx = first_one(sel_r);
  wire logic sel_ok = (|sel_r) && txe_r[sidx]; // R4 R7 R9
  wire logic wr_flag = reg_wr_i && (reg_addr_i == `OFS_TX_FLAG);
  wire logic wr_abt = reg_wr_i && (reg_addr_i == `OFS_ABT_REQ);
  wire logic wr_rxf = reg_wr_i && (reg_addr_i == `OFS_RX_FLAG);
  wire logic full_w = rx_cnt_r == PW'(RX_DEPTH);
  wire logic push_w = rx_ok_i && accept_hit_i && (!in_tx_r || loop_w) && !init_w; // R19 R20 R21
  wire logic pop_w = wr_rxf && reg_wdata_i[`RXF_BIT] && (rx_cnt_r != '0); // R18
  wire logic store_w = push_w && (!full_w || pop_w); // R22

  // Control register: init, stamping, loopback
  always_ff @(posedge mclk_i)
  begin
    if (!rst_n_i)
    begin
      ctrl_r <= `CTRL_RESET;
    end
    else if (reg_wr_i && (reg_addr_i == `OFS_CTRL))
    begin
      ctrl_r <= reg_wdata_i[2:0];
    end
  end

  // Buffer select keeps only the lowest requested empty buffer
  always_ff @(posedge mclk_i)
  begin
    if (!rst_n_i)
    begin
      sel_r <= 3'h0;
    end
    else if (reg_wr_i && (reg_addr_i == `OFS_TX_SEL))
    begin
      sel_r <= (reg_wdata_i[2:0] & txe_r) & ~((reg_wdata_i[2:0] & txe_r) - 3'h1); // R9
    end
  end

  // Next state of empty flags, abort request and acknowledge
  always_comb
  begin
    txe_nxt = txe_r;
    abt_req_nxt = abt_req_r;
    abt_ack_nxt = abt_ack_r;
    in_tx_nxt = in_tx_r;
    if (wr_flag)
    begin
      txe_nxt = txe_r & ~reg_wdata_i[2:0]; // R10
      abt_ack_nxt = abt_ack_r & ~(reg_wdata_i[2:0] & txe_r);
    end
    if (wr_abt)
    begin
      abt_req_nxt = abt_req_r | (reg_wdata_i[2:0] & ~txe_r); // R13
    end
    if (tx_start_i && tx_pick_r.valid && !txe_r[tx_pick_r.idx])
    begin
      in_tx_nxt = 1'b1;
    end
    if (tx_error_i || arb_lost_i)
    begin
      in_tx_nxt = 1'b0; // R12 R21
    end
    for (int i = 0; i < 3; i++)
    begin
      if (abt_req_r[i] && !txe_r[i] && !(in_tx_r && (act_r == 2'(i))))
      begin
        txe_nxt[i] = 1'b1; // R13
        abt_ack_nxt[i] = 1'b1; // R14
        abt_req_nxt[i] = 1'b0;
      end
    end
    if (tx_done_i && in_tx_r)
    begin
      txe_nxt[act_r] = 1'b1; // R10
      abt_ack_nxt[act_r] = 1'b0; // R14
      abt_req_nxt[act_r] = 1'b0;
      in_tx_nxt = 1'b0;
    end
  end

  // Transmit flag state; init forces every buffer empty
  always_ff @(posedge mclk_i)
  begin
    if (!rst_n_i || init_w)
    begin
      txe_r <= `TXE_RESET; // R24
      abt_req_r <= 3'h0;
      abt_ack_r <= 3'h0;
      in_tx_r <= 1'b0;
      act_r <= 2'd0;
      tx_ev_r <= 3'h0;
    end
    else
    begin
      txe_r <= txe_nxt;
      abt_req_r <= abt_req_nxt;
      abt_ack_r <= abt_ack_nxt;
      in_tx_r <= in_tx_nxt;
      tx_ev_r <= txe_nxt & ~txe_r; // R11
      if (tx_start_i && tx_pick_r.valid && !txe_r[tx_pick_r.idx])
      begin
        act_r <= tx_pick_r.idx;
      end
    end
  end

  AST_INIT_EMPTY: assert property (init_w |=> txe_r == 3'h7 && rx_cnt_r == '0) // R24
    else $error("init did not empty buffers");
  AST_TX_EVENT: assert property ($rose(txe_r[1]) && !$past(init_w) |-> tx_event_o[1]) // R11
    else $error("empty flag set without event");
  AST_DONE_EMPTY: assert property (tx_done_i && in_tx_r && !init_w |=> // R10
    txe_r[$past(act_r)] && !abt_ack_r[$past(act_r)])
    else $error("sent buffer not released as sent");
  AST_ABORT: assert property (abt_req_r[0] && !txe_r[0] && !(in_tx_r && act_r == 2'd0) // R13
    && !init_w |=> txe_r[0] && abt_ack_r[0] && !abt_req_r[0])
    else $error("abort not granted");

  // Message bytes written through the transmit window
  always_ff @(posedge mclk_i)
  begin
    if (reg_wr_i && tx_page && sel_ok && (win_idx < 4'(`MSG_BYTES)))
    begin
      tx_mem[sidx][win_idx] <= reg_wdata_i; // R8 R9
    end
  end

  // Local priority per buffer, stamp bytes in the window ignore writes
  always_ff @(posedge mclk_i)
  begin
    if (!rst_n_i)
    begin
      for (int i = 0; i < 3; i++)
      begin
        tx_local_priority_field_r[i] <= 8'h00;
      end
    end
    else if (reg_wr_i && tx_page && sel_ok && (win_idx == `TX_LOCAL_PRIORITY_FIELD_IDX))
    begin
      tx_local_priority_field_r[sidx] <= reg_wdata_i; // R3 R4 R7
    end
  end

  // Transmit stamp taken when own frame is acknowledged
  always_ff @(posedge mclk_i)
  begin
    if (!rst_n_i)
    begin
      for (int i = 0; i < 3; i++)
      begin
        tx_stamp_r[i] <= 16'h0000;
      end
    end
    else if (time_w && bus_ack_i && in_tx_r)
    begin
      tx_stamp_r[act_r] <= timer_r; // R5
    end
  end

  AST_STAMP: assert property (time_w && bus_ack_i && in_tx_r && !init_w |=> // R5
    tx_stamp_r[$past(act_r)] == $past(timer_r))
    else $error("transmit stamp not taken");

  // Pending buffer with the lowest priority value; ties go to lower index
  always_comb
  begin
    best = 2'd0;
    found = 1'b0;
    for (int i = 0; i < 3; i++)
    begin
      if (!txe_r[i] && (!found || (tx_local_priority_field_r[i] < tx_local_priority_field_r[best]))) // R1 R2
      begin
        best = 2'(i);
        found = 1'b1;
      end
    end
  end

  // Pick is rerun at every SOF request, retries included
  always_ff @(posedge mclk_i)
  begin
    if (!rst_n_i || init_w)
    begin
      tx_pick_r <= '0;
      tx_msg_r <= '0;
    end
    else if (sof_req_i)
    begin
      tx_pick_r.valid <= found; // R12
      if (found)
      begin
        tx_pick_r.idx <= best;
        tx_pick_r.count <= data_count(tx_mem[best][`IDR1_BYTE], // R23
          tx_mem[best][`IDR3_BYTE], tx_mem[best][`DLR_BYTE]);
        for (int b = 0; b < `MSG_BYTES; b++)
        begin
          tx_msg_r[8*b +: 8] <= tx_mem[best][b];
        end
      end
    end
  end

  AST_PICK_NONE: assert property (sof_req_i && txe_r == 3'h7 && !init_w |=> // R1
    !tx_pick_o.valid)
    else $error("pick valid with no pending buffer");
  AST_PICK_ANY: assert property (sof_req_i && !txe_r[2] && !init_w |=> tx_pick_o.valid) // R1
    else $error("pending buffer left out of pick");
  AST_PICK_LOW: assert property (sof_req_i && !txe_r[0] && !init_w // R2
    && tx_local_priority_field_r[0] <= tx_local_priority_field_r[1] && tx_local_priority_field_r[0] <= tx_local_priority_field_r[2]
    |=> tx_pick_o.idx == 2'd0)
    else $error("wrong buffer picked");

  // Free running bit-time stamp timer, wraps with no indication
  always_ff @(posedge mclk_i)
  begin
    if (!rst_n_i || init_w)
    begin
      div_r <= '0;
      timer_r <= 16'h0000; // R6
    end
    else if (div_r == DW'(BIT_DIV - 1))
    begin
      div_r <= '0;
      timer_r <= timer_r + 16'h0001; // R6
    end
    else
    begin
      div_r <= div_r + DW'(1);
    end
  end

  AST_TIMER_INIT: assert property (init_w |=> timer_r == 16'h0000) // R6
    else $error("timer not held in init");

  // Background buffer: every frame lands here, own ones included
  always_ff @(posedge mclk_i)
  begin
    if (!rst_n_i)
    begin
      for (int b = 0; b < `RX_BYTES; b++)
      begin
        bg_mem[b] <= 8'h00;
      end
    end
    else
    begin
      if (rx_wr_i.we && (rx_wr_i.idx < 4'(`MSG_BYTES)))
      begin
        bg_mem[rx_wr_i.idx] <= rx_wr_i.data; // R19 R20 R21
      end
      if (time_w && bus_ack_i)
      begin
        bg_mem[`RX_STH_IDX] <= timer_r[15:8]; // R5
        bg_mem[`RX_STL_IDX] <= timer_r[7:0];
      end
    end
  end

  // FIFO pointers, fill count and overrun flag
  always_ff @(posedge mclk_i)
  begin
    if (!rst_n_i || init_w)
    begin
      rd_ptr_r <= '0;
      wr_ptr_r <= '0;
      rx_cnt_r <= '0; // R24
      ovr_r <= 1'b0;
      rx_ev_r <= 1'b0;
      ovr_ev_r <= 1'b0;
    end
    else
    begin
      if (store_w)
      begin
        wr_ptr_r <= ptr_inc(wr_ptr_r); // R17
      end
      if (pop_w)
      begin
        rd_ptr_r <= ptr_inc(rd_ptr_r); // R18
      end
      if (store_w && !pop_w)
      begin
        rx_cnt_r <= rx_cnt_r + PW'(1);
      end
      else if (pop_w && !store_w)
      begin
        rx_cnt_r <= rx_cnt_r - PW'(1);
      end
      if (push_w && !store_w)
      begin
        ovr_r <= 1'b1; // R22
      end
      else if (wr_rxf && reg_wdata_i[`OVR_BIT])
      begin
        ovr_r <= 1'b0;
      end
      rx_ev_r <= store_w; // R17
      ovr_ev_r <= push_w && !store_w; // R22
    end
  end

  // FIFO entries take a copy of the background buffer
  always_ff @(posedge mclk_i)
  begin
    if (store_w)
    begin
      for (int b = 0; b < `RX_BYTES; b++)
      begin
        rx_mem[wr_ptr_r][b] <= bg_mem[b]; // R15
      end
    end
  end

  AST_STORE: assert property (push_w && !full_w && !pop_w |=> // R17
    rx_cnt_r == $past(rx_cnt_r) + PW'(1) && rx_event_o && rx_full_flag_o)
    else $error("accepted message not queued");
  AST_OVERRUN: assert property (push_w && full_w && !pop_w |=> // R22
    rx_cnt_r == PW'(RX_DEPTH) && ovr_r && overrun_event_o)
    else $error("overrun not flagged");
  AST_OWN: assert property (rx_ok_i && in_tx_r && !loop_w && !pop_w && !init_w |=> // R20
    rx_cnt_r == $past(rx_cnt_r) && !rx_event_o)
    else $error("own frame queued");

  // Register read mux; windows read zero when not accessible
  always_comb
  begin
    rd_val = 8'h00;
    case (reg_addr_i)
      `OFS_TX_FLAG: rd_val = {5'h00, txe_r};
      `OFS_TX_SEL: rd_val = {5'h00, sel_r};
      `OFS_ABT_REQ: rd_val = {5'h00, abt_req_r};
      `OFS_ABT_ACK: rd_val = {5'h00, abt_ack_r}; // R14
      `OFS_RX_FLAG: rd_val = {6'h00, ovr_r, rx_cnt_r != '0}; // R16
      `OFS_CTRL: rd_val = {5'h00, ctrl_r};
      default:
      begin
        if (tx_page && sel_ok)
        begin
          if (win_idx < 4'(`MSG_BYTES))
          begin
            rd_val = tx_mem[sidx][win_idx];
          end
          else if (win_idx == `TX_LOCAL_PRIORITY_FIELD_IDX)
          begin
            rd_val = tx_local_priority_field_r[sidx]; // R4
          end
          else if (win_idx == `TX_STH_IDX)
          begin
            rd_val = tx_stamp_r[sidx][15:8]; // R7
          end
          else
          begin
            rd_val = tx_stamp_r[sidx][7:0];
          end
        end
        else if (rx_page && (rx_cnt_r != '0) && (win_idx < 4'(`RX_BYTES)))
        begin
          rd_val = rx_mem[rd_ptr_r][win_idx]; // R15
        end
      end
    endcase
  end

  // Read data stands only in the cycle after the strobe
  always_ff @(posedge mclk_i)
  begin
    if (!rst_n_i)
    begin
      rdata_r <= 8'h00;
    end
    else
    begin
      rdata_r <= reg_rd_i ? rd_val : 8'h00;
    end
  end

  // Outputs
  assign reg_rdata_o = rdata_r;
  assign tx_pick_o = tx_pick_r;
  assign tx_msg_o = tx_msg_r;
  assign tx_buffer_empty_o = txe_r;
  assign tx_event_o = tx_ev_r;
  assign rx_full_flag_o = rx_cnt_r != '0; // R16
  assign rx_event_o = rx_ev_r;
  assign overrun_event_o = ovr_ev_r;
endmodule : can_message_buffer_store
`default_nettype wire

// >>> core/can_msg_params.svh
// Offsets, field positions, reset values and counts of the message buffer store
`ifndef CAN_MSG_PARAMS_SVH
`define CAN_MSG_PARAMS_SVH
`define OFS_TX_FLAG 8'h00
`define OFS_TX_SEL 8'h01
`define OFS_ABT_REQ 8'h02
`define OFS_ABT_ACK 8'h03
`define OFS_RX_FLAG 8'h04
`define OFS_CTRL 8'h05
`define TX_PAGE 4'h1
`define RX_PAGE 4'h2
`define MSG_BYTES 13
`define RX_BYTES 15
`define TX_LOCAL_PRIORITY_FIELD_IDX 4'hD
`define TX_STH_IDX 4'hE
`define TX_STL_IDX 4'hF
`define RX_STH_IDX 4'hD
`define RX_STL_IDX 4'hE
`define IDR1_BYTE 1
`define IDR3_BYTE 3
`define DLR_BYTE 12
`define IDE_BIT 3
`define RTR_STD_BIT 4
`define RTR_EXT_BIT 0
`define MAX_DATA 4'h8
`define CTRL_INIT_BIT 0
`define CTRL_TIME_BIT 1
`define CTRL_LOOP_BIT 2
`define RXF_BIT 0
`define OVR_BIT 1
`define CTRL_RESET 3'h1
`define TXE_RESET 3'h7
`define RX_DEPTH_DEF 5
`define BIT_DIV_DEF 100
`endif

// >>> core/can_msg_pkg.sv
// Types shared by the message buffer store and its users
package can_msg_pkg;
  typedef logic [7:0] byte_t;
  typedef struct packed {
    logic valid;
    logic [1:0] idx;
    logic [3:0] count;
  } tx_pick_t;
  typedef struct packed {
    logic we;
    logic [3:0] idx;
    logic [7:0] data;
  } rx_wr_t;
endpackage : can_msg_pkg

// >>> tb/can_engine_model.sv
// Behavioural protocol engine driving the network side of the buffer store
`timescale 1ns/1ps
`default_nettype none
module can_engine_model (
  input wire logic mclk_i, // Controller clock
  output logic sof_req_o, // About to send SOF
  output logic tx_start_o, // Picked frame goes out
  output logic tx_done_o, // Frame sent clean
  output logic tx_error_o, // Frame broke on the bus
  output logic arb_lost_o, // Lost arbitration
  output logic bus_ack_o, // Acknowledge slot seen
  output can_msg_pkg::rx_wr_t rx_wr_o, // Byte into background buffer
  output logic rx_ok_o, // Frame received clean
  output logic accept_hit_o // Filter verdict
);
  import can_msg_pkg::*;
  // Idle bus at time zero
  initial
  begin
    {sof_req_o, tx_start_o, tx_done_o, tx_error_o, arb_lost_o, bus_ack_o} = '0;
    rx_wr_o = '0;
    rx_ok_o = 1'b0;
    accept_hit_o = 1'b0;
  end
  // One arbitration attempt, also every retry
  task automatic arbitrate();
    @(posedge mclk_i);
    sof_req_o <= 1'b1;
    @(posedge mclk_i);
    sof_req_o <= 1'b0;
  endtask : arbitrate
  // Send picked frame: 0 clean, 1 error, 2 lost arbitration
  task automatic send(input int mode, input bit own_rx);
    @(posedge mclk_i);
    tx_start_o <= 1'b1;
    @(posedge mclk_i);
    tx_start_o <= 1'b0;
    if (mode == 2)
    begin
      arb_lost_o <= 1'b1;
    end
    else
    begin
      bus_ack_o <= 1'b1;
      @(posedge mclk_i);
      bus_ack_o <= 1'b0;
      rx_ok_o <= own_rx;
      accept_hit_o <= own_rx;
      @(posedge mclk_i);
      rx_ok_o <= 1'b0;
      accept_hit_o <= 1'b0;
      tx_done_o <= (mode == 0);
      tx_error_o <= (mode == 1);
    end
    @(posedge mclk_i);
    {tx_done_o, tx_error_o, arb_lost_o} <= '0;
  endtask : send
  // Receive a frame byte by byte, then report it
  task automatic rx_frame(input byte_t b [13], input bit hit);
    for (int i = 0; i < 13; i++)
    begin
      @(posedge mclk_i);
      rx_wr_o <= '{we: 1'b1, idx: 4'(i), data: b[i]};
    end
    @(posedge mclk_i);
    rx_wr_o <= '{we: 1'b0, idx: 4'hF, data: ~b[12]}; // Released line shows no stale byte
    bus_ack_o <= 1'b1;
    @(posedge mclk_i);
    bus_ack_o <= 1'b0;
    rx_ok_o <= 1'b1;
    accept_hit_o <= hit;
    @(posedge mclk_i);
    rx_ok_o <= 1'b0;
    accept_hit_o <= 1'b0;
  endtask : rx_frame
endmodule : can_engine_model
`default_nettype wire

// >>> tb/can_message_buffer_store_tb.sv
// Self-checking bench for the message buffer store against a queue model
`timescale 1ns/1ps
`default_nettype none
`include "can_msg_params.svh"
`define CHK(nm, exp, got) \
  begin \
    num_checks++; \
    if ((got) !== (exp)) \
    begin \
      err_count++; \
      $display("wrong value %s expected %0h seen %0h", nm, exp, got); \
    end \
  end
module can_message_buffer_store_tb;
  import can_msg_pkg::*;
  localparam int DEPTH = 5;
  localparam int DIV = 2;
  typedef byte_t frame_t [13];
  logic mclk = 1'b0;
  logic rst_n = 1'b0;
  logic [7:0] addr = 8'h00;
  logic [7:0] wdata = 8'h00;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [7:0] rdata;
  logic sof, start, done, txerr, lost, ack_b, rx_ok, hit, rx_full, rx_ev, ovr_ev;
  rx_wr_t rx_wr;
  tx_pick_t pick;
  logic [8*`MSG_BYTES-1:0] tx_msg;
  logic [2:0] empty, tx_ev;
  int err_count = 0;
  int num_checks = 0;
  int cycles = 0;
  integer seed = 32'h8D72;
  byte_t msg [3][13];
  byte_t local_priority_field [3];
  logic [2:0] emp = 3'h7;
  logic [2:0] abk = 3'h0;
  frame_t fifo [$];
  // Controller clock, 100 MHz
  initial
  begin
    forever #5 mclk = ~mclk;
  end
  can_message_buffer_store #(.RX_DEPTH(DEPTH), .BIT_DIV(DIV)) u_can_message_buffer_store (
    .mclk_i(mclk), .rst_n_i(rst_n), .reg_addr_i(addr), .reg_wdata_i(wdata),
    .reg_wr_i(reg_wr), .reg_rd_i(reg_rd), .reg_rdata_o(rdata), .sof_req_i(sof),
    .tx_start_i(start), .tx_done_i(done), .tx_error_i(txerr), .arb_lost_i(lost),
    .bus_ack_i(ack_b), .tx_pick_o(pick), .tx_msg_o(tx_msg), .rx_wr_i(rx_wr),
    .rx_ok_i(rx_ok), .accept_hit_i(hit), .tx_buffer_empty_o(empty), .tx_event_o(tx_ev),
    .rx_full_flag_o(rx_full), .rx_event_o(rx_ev), .overrun_event_o(ovr_ev));
  can_engine_model u_can_engine_model (
    .mclk_i(mclk), .sof_req_o(sof), .tx_start_o(start), .tx_done_o(done),
    .tx_error_o(txerr), .arb_lost_o(lost), .bus_ack_o(ack_b), .rx_wr_o(rx_wr),
    .rx_ok_o(rx_ok), .accept_hit_o(hit));
  // One-cycle register write
  task automatic bus_wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge mclk);
    reg_wr <= 1'b1;
    addr <= a;
    wdata <= d;
    @(posedge mclk);
    reg_wr <= 1'b0;
  endtask : bus_wr
  // One-cycle register read, data taken in the following cycle
  task automatic bus_rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge mclk);
    reg_rd <= 1'b1;
    addr <= a;
    @(posedge mclk);
    reg_rd <= 1'b0;
    #1 d = rdata;
  endtask : bus_rd
  // Lowest priority value among pending buffers, lower index on ties
  function automatic int exp_pick();
    int best;
    best = -1;
    for (int b = 0; b < 3; b++)
      if (!emp[b] && (best < 0 || local_priority_field[b] < local_priority_field[best]))
        best = b;
    return best;
  endfunction : exp_pick
  // Data bytes to send: none for remote frames, capped at eight
  function automatic logic [3:0] exp_cnt(int b);
    logic rtr;
    rtr = msg[b][`IDR1_BYTE][`IDE_BIT] ? msg[b][`IDR3_BYTE][`RTR_EXT_BIT]
                                       : msg[b][`IDR1_BYTE][`RTR_STD_BIT];
    if (rtr)
      return 4'h0;
    return (msg[b][`DLR_BYTE][3:0] > `MAX_DATA) ? `MAX_DATA : msg[b][`DLR_BYTE][3:0];
  endfunction : exp_cnt
  // Verdict and end of run
  task automatic close_out();
    $display("checks %0d mismatches %0d", num_checks, err_count);
    if (err_count == 0 && num_checks > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask : close_out
  // Hang guard
  always @(posedge mclk)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      err_count++;
      close_out();
    end
  end
  // Main sequence
  initial
  begin
    logic [7:0] d, h;
    int b, last;
    int modes [5];
    int t0;
    frame_t f;
    modes = '{1, 2, 0, 0, 0};
    repeat (4) @(posedge mclk);
    rst_n <= 1'b1;
    #1 `CHK("empty after reset", 3'h7, empty);
    `CHK("rx full after reset", 1'b0, rx_full);
    bus_rd(`OFS_TX_FLAG, d);
    `CHK("tx flags", 8'h07, d);
    bus_rd(8'h40, d);
    `CHK("unmapped read", 8'h00, d);
    bus_rd({`TX_PAGE, `TX_LOCAL_PRIORITY_FIELD_IDX}, d);
    `CHK("priority unselected", 8'h00, d);
    $display("test reset done");
    bus_wr(`OFS_CTRL, 8'h02); // Leave init, stamping on
    for (b = 0; b < 3; b++)
    begin
      bus_wr(`OFS_TX_SEL, 8'h07 & ~((8'h01 << b) - 8'h01));
      bus_rd(`OFS_TX_SEL, d);
      `CHK("select", 8'h01 << b, d);
      for (int i = 0; i < 13; i++)
      begin
        msg[b][i] = 8'($random(seed));
        bus_wr({`TX_PAGE, 4'(i)}, msg[b][i]);
      end
      local_priority_field[b] = (b == 2) ? local_priority_field[0] : 8'($random(seed));
      bus_wr({`TX_PAGE, `TX_LOCAL_PRIORITY_FIELD_IDX}, local_priority_field[b]);
      bus_rd({`TX_PAGE, `TX_LOCAL_PRIORITY_FIELD_IDX}, d);
      `CHK("priority", local_priority_field[b], d);
    end
    bus_wr(`OFS_TX_FLAG, 8'h07);
    emp = 3'h0;
    bus_rd({`TX_PAGE, `TX_LOCAL_PRIORITY_FIELD_IDX}, d);
    `CHK("priority while pending", 8'h00, d);
    bus_rd(`OFS_TX_FLAG, d);
    `CHK("tx flags pending", 8'h00, d);
    $display("test load done");
    for (int r = 0; r < 5; r++)
    begin
      u_can_engine_model.arbitrate();
      b = exp_pick();
      #1 `CHK("pick valid", (b >= 0), pick.valid);
      if (b < 0)
        break;
      `CHK("pick idx", 2'(b), pick.idx);
      `CHK("pick count", exp_cnt(b), pick.count);
      `CHK("pick dlr", msg[b][`DLR_BYTE], tx_msg[8*`DLR_BYTE +: 8]);
      u_can_engine_model.send(modes[r], modes[r] == 0);
      #1;
      if (modes[r] == 1)
      begin
        `CHK("empty after error", emp, empty);
        bus_wr(`OFS_ABT_REQ, 8'h01 << b);
        @(posedge mclk);
        emp[b] = 1'b1;
        abk[b] = 1'b1;
        #1 `CHK("tx event abort", 3'(1 << b), tx_ev);
      end
      else if (modes[r] == 2)
      begin
        for (int i = 0; i < 13; i++)
          f[i] = 8'($random(seed));
        u_can_engine_model.rx_frame(f, 1'b1);
        fifo.push_back(f);
        #1 `CHK("rx event after lost", 1'b1, rx_ev);
      end
      else
      begin
        emp[b] = 1'b1;
        last = b;
        `CHK("tx event sent", 3'(1 << b), tx_ev);
      end
      `CHK("empty flags", emp, empty);
      bus_rd(`OFS_ABT_ACK, d);
      `CHK("abort ack", {5'h00, abk}, d);
    end
    $display("test transmit done");
    bus_wr(`OFS_TX_SEL, 8'h01 << last);
    bus_rd({`TX_PAGE, `TX_STH_IDX}, h);
    bus_rd({`TX_PAGE, `TX_STL_IDX}, d);
    `CHK("stamp taken", 1'b1, ({h, d} != 16'h0000));
    bus_wr({`TX_PAGE, `TX_STH_IDX}, ~h);
    bus_rd({`TX_PAGE, `TX_STH_IDX}, d);
    `CHK("stamp read only", h, d);
    $display("test stamp done");
    for (int k = 0; k < DEPTH + 2; k++)
    begin
      for (int i = 0; i < 13; i++)
        f[i] = 8'($random(seed));
      b = (fifo.size() == DEPTH);
      u_can_engine_model.rx_frame(f, k != 2);
      #1 `CHK("rx event", (k != 2) && !b, rx_ev);
      `CHK("overrun event", (k != 2) && b, ovr_ev);
      if (k != 2 && !b)
        fifo.push_back(f);
    end
    `CHK("rx full", 1'b1, rx_full);
    while (fifo.size() > 0)
    begin
      for (int i = 0; i < 13; i++)
      begin
        bus_rd({`RX_PAGE, 4'(i)}, d);
        `CHK("rx byte", fifo[0][i], d);
      end
      bus_rd(`OFS_RX_FLAG, d);
      `CHK("rx flags", 8'h03, d);
      bus_wr(`OFS_RX_FLAG, 8'h01);
      void'(fifo.pop_front());
    end
    #1 `CHK("rx full drained", 1'b0, rx_full);
    bus_rd({`RX_PAGE, 4'h0}, d);
    `CHK("rx window empty", 8'h00, d);
    bus_wr(`OFS_RX_FLAG, 8'h02);
    bus_rd(`OFS_RX_FLAG, d);
    `CHK("overrun cleared", 8'h00, d);
    $display("test receive done");
    bus_wr(`OFS_TX_FLAG, 8'h04);
    bus_wr(`OFS_CTRL, 8'h01); // Back into init with a buffer pending
    @(posedge mclk);
    #1 `CHK("empty after init", 3'h7, empty);
    bus_wr(`OFS_CTRL, 8'h06); // Leave init with loopback and stamping
    #1 t0 = cycles;
    bus_wr(`OFS_TX_FLAG, 8'h02);
    u_can_engine_model.arbitrate();
    #1 `CHK("pick after init", 2'h1, pick.idx);
    u_can_engine_model.send(0, 1'b1);
    #1 `CHK("loopback queued", 1'b1, rx_full);
    `CHK("tx event loopback", 3'h2, tx_ev);
    // Timer restarts on leaving init; acknowledge was sampled two edges before return
    t0 = (cycles - 3 - t0) / DIV;
    bus_wr(`OFS_TX_SEL, 8'h02);
    bus_rd({`TX_PAGE, `TX_STH_IDX}, h);
    bus_rd({`TX_PAGE, `TX_STL_IDX}, d);
    `CHK("stamp after init", 16'(t0), {h, d});
    bus_wr(`OFS_RX_FLAG, 8'h01);
    $display("test init done");
    close_out();
  end
endmodule : can_message_buffer_store_tb
`default_nettype wire
